// ===== include/mms_pkg.sv
// constants shared by both ends of the serial management link.
// assumes nothing beyond a systemverilog compiler.
package mms_pkg;
   // frame layout
   localparam logic [5:0] PRE_LEN = 6'h20; // preamble ones needed
   localparam logic [1:0] SFD_PAT = 2'h1; // start delimiter 0 then 1
   localparam logic [1:0] OP_RD = 2'h2;
   localparam logic [1:0] OP_WR = 2'h1;
   localparam logic [1:0] TA_WR = 2'h2; // controller sends 1 then 0
   localparam logic [3:0] HDR_LAST = 4'hB; // op + phy + reg = 12 bits
   localparam logic [3:0] DATA_LAST = 4'hF; // 16 data bits
   localparam int DATA_W = 16;
   localparam int ADDR_W = 5;
   localparam int NREG = 32;
   localparam logic [6:0] FRAME_BITS = 7'h20; // sfd to last data bit
   localparam logic [6:0] PRE_FRAME_BITS = 7'h40; // with preamble
   localparam logic [6:0] TA_DATA_BITS = 7'h12; // turnaround + data
   localparam logic [6:0] DATA_BITS = 7'h10;
   localparam logic [31:0] PRE_WORD = 32'hFFFF_FFFF;
   // register map
   localparam logic [4:0] REG_STATUS = 5'h01;
   localparam logic [4:0] REG_ID_HI = 5'h02;
   localparam logic [4:0] REG_ID_LO = 5'h03;
   localparam logic [4:0] REG_EXT = 5'h10;
   localparam int BIT_PRE_SUP = 6; // preamble suppression, status reg
   localparam int BIT_OVR = 15; // command override, ext reg
   localparam int PHYAD_LSB = 6;
   localparam int PHYAD_MSB = 10;
   localparam logic [15:0] EXT_RW_MASK = 16'hF83F; // phy address is read only
   localparam logic [15:0] STATUS_CW_MASK = 16'h0040;
   localparam logic [15:0] ALL_ONES = 16'hFFFF;
   localparam logic [15:0] NO_BITS = 16'h0000;
   localparam logic [31:0] IMPL_DEFAULT = 32'h000F_01FF; // regs 0-8, 16-19
endpackage

// ===== include/mms_if.sv
// two-wire management link between controller and device.
// assumes an external pull-up: the line reads one when nobody drives it.
`timescale 1ns/100ps
interface mms_if;
   logic mdc;
   logic mdio_sta_o;
   logic mdio_sta_oe;
   logic mdio_dev_o;
   logic mdio_dev_oe;
   logic mdio;
   // wire level from the two enables, pull-up when both released
   assign mdio = mdio_sta_oe ? mdio_sta_o : (mdio_dev_oe ? mdio_dev_o : 1'b1);
   modport sta (
      output mdc,
      output mdio_sta_o,
      output mdio_sta_oe,
      input mdio
   );
   modport dev (
      input mdc,
      input mdio,
      output mdio_dev_o,
      output mdio_dev_oe
   );
endinterface

// ===== hw/mms_sta.sv
// station management controller end: builds frames and drives mdc.
// assumes one command at a time on the system clock; mdc is divided down.
`timescale 1ns/100ps
module mms_sta
   import mms_pkg::*;
#(
   parameter int HALF = 10 // system clocks per mdc half period
) (
   input wire logic clock,
   input wire logic arst_n,
   mms_if.sta link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_write,
   input wire logic cmd_preamble,
   input wire logic [4:0] cmd_phyad,
   input wire logic [4:0] cmd_regad,
   input wire logic [15:0] cmd_wdata,
   output logic resp_valid,
   output logic [15:0] resp_rdata
);
   // the divider counter is 8 bits and a half period needs two states
   if (HALF < 2 || HALF > 255) begin : g_half_check
      $error("mms_sta: HALF must be 2..255");
   end

   typedef struct packed {
      logic busy;
      logic mdc;
      logic [7:0] div;
      logic [6:0] left;
      logic [63:0] sh;
      logic rd;
      logic oe;
      logic out;
      logic [15:0] rdata;
      logic s1;
      logic s2;
      logic s3;
      logic filt;
      logic resp_valid;
      logic [15:0] resp_rdata;
   } mms_sta_t;

   localparam logic [7:0] HALF_LAST = 8'(HALF - 1);

   mms_sta_t r;
   mms_sta_t next_r;
   logic [31:0] frame;

   // frame after the preamble, first bit in the top position
   assign frame = {SFD_PAT, cmd_write ? OP_WR : OP_RD, cmd_phyad, cmd_regad,
                   cmd_write ? TA_WR : 2'h0, cmd_write ? cmd_wdata : NO_BITS};

   always_comb begin
      next_r = r;
      next_r.resp_valid = 1'b0;
      // pin input: three flops, accepted once the last two agree
      next_r.s1 = link.mdio;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      if (r.s2 == r.s3) begin
         next_r.filt = r.s3;
      end
      if (!r.busy) begin
         next_r.mdc = 1'b0;
         if (cmd_valid) begin
            next_r.busy = 1'b1;
            next_r.div = 8'h00;
            next_r.rd = !cmd_write;
            // 32 ones ahead of the frame unless suppression is wanted
            next_r.sh = cmd_preamble ? {PRE_WORD, frame} : {frame, PRE_WORD};
            next_r.left = cmd_preamble ? PRE_FRAME_BITS : FRAME_BITS;
         end
      end else if (r.div == HALF_LAST) begin
         next_r.div = 8'h00;
         if (!r.mdc) begin
            // rising edge: the device samples here, we take read data
            next_r.mdc = 1'b1;
            if (r.rd && r.left <= DATA_BITS) begin
               next_r.rdata = {r.rdata[14:0], r.filt};
            end
         end else begin
            // falling edge: next bit goes out with it
            next_r.mdc = 1'b0;
            next_r.left = r.left - 7'h01;
            next_r.sh = {r.sh[62:0], 1'b0};
            if (r.left == 7'h01) begin
               next_r.busy = 1'b0;
               next_r.resp_valid = r.rd;
               next_r.resp_rdata = r.rdata;
            end
         end
      end else begin
         next_r.div = r.div + 8'h01;
      end
      // release the line from the read turnaround onward
      next_r.out = next_r.sh[63];
      next_r.oe = next_r.busy && !(next_r.rd && next_r.left <= TA_DATA_BITS);
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign cmd_ready = !r.busy;
   assign resp_valid = r.resp_valid;
   assign resp_rdata = r.resp_rdata;
   assign link.mdc = r.mdc;
   assign link.mdio_sta_o = r.out;
   assign link.mdio_sta_oe = r.oe;
endmodule // mms_sta

// ===== hw/mms_dev.sv
// device end of the management link: frame decoder and register file.
// assumes mdc from the controller clocks the link logic and may stop
// between frames; register writes are reported on the system clock.
`timescale 1ns/100ps
module mms_dev
   import mms_pkg::*;
#(
   parameter logic [31:0] IMPL = IMPL_DEFAULT, // implemented registers
   parameter logic [15:0] STATUS_INIT = 16'h0000, // status reset value; bit 6 is cleared at reset and writable after an override, the rest read only
   parameter logic [15:0] ID_HI_INIT = 16'h0000, // arbitrary identity value
   parameter logic [15:0] ID_LO_INIT = 16'h0000 // arbitrary identity value
) (
   input wire logic clock,
   input wire logic arst_n,
   mms_if.dev link,
   input wire logic [4:0] phyad_strap,
   output logic reg_wr_pulse,
   output logic [4:0] reg_wr_addr,
   output logic [15:0] reg_wr_data
);
   // suppression and override live in these two registers
   if (IMPL[REG_STATUS] == 1'b0 || IMPL[REG_EXT] == 1'b0) begin : g_impl_check
      $error("mms_dev: status and extended control must be implemented");
   end

   typedef enum logic [2:0] {
      ST_HUNT,
      ST_SFD,
      ST_HDR,
      ST_TA1,
      ST_TA2,
      ST_DATA
   } mms_dstate_t;

   // link-side state, clocked by mdc
   typedef struct packed {
      mms_dstate_t st;
      logic [5:0] ones;
      logic [3:0] cnt;
      logic [11:0] hdr;
      logic [15:0] sh;
      logic act;
      logic rd;
      logic oe;
      logic out;
      logic [NREG-1:0][DATA_W-1:0] regs;
      logic wtog;
      logic [4:0] waddr;
      logic [15:0] wdata;
      logic [4:0] a1;
      logic [4:0] a2;
      logic [4:0] a3;
   } mms_link_t;

   // system-side state
   typedef struct packed {
      logic t1;
      logic t2;
      logic t3;
      logic seen;
      logic pulse;
      logic [4:0] addr;
      logic [15:0] data;
   } mms_sys_t;

   mms_link_t r;
   mms_link_t next_r;
   mms_sys_t q;
   mms_sys_t next_q;

   // bits software may always change
   function automatic logic [15:0] rw_mask(input logic [4:0] a);
      case (a)
         REG_STATUS: rw_mask = NO_BITS;
         REG_ID_HI: rw_mask = NO_BITS;
         REG_ID_LO: rw_mask = NO_BITS;
         REG_EXT: rw_mask = EXT_RW_MASK;
         default: rw_mask = ALL_ONES;
      endcase
   endfunction

   // bits that change only right after a command override
   function automatic logic [15:0] cw_mask(input logic [4:0] a);
      cw_mask = (a == REG_STATUS) ? STATUS_CW_MASK : NO_BITS;
   endfunction

   logic bit_in;
   logic pre_sup;
   logic ovr;
   logic [11:0] hdr_new;
   logic [4:0] reg_a;
   logic [15:0] wr_word;
   logic [15:0] wr_mask;
   logic [15:0] rd_word;

   assign bit_in = link.mdio; // same domain as mdc, no synchroniser
   assign pre_sup = r.regs[REG_STATUS][BIT_PRE_SUP];
   assign ovr = r.regs[REG_EXT][BIT_OVR];
   assign hdr_new = {r.hdr[10:0], bit_in};
   assign reg_a = r.hdr[4:0];
   assign wr_word = {r.sh[14:0], bit_in};
   assign wr_mask = rw_mask(reg_a) | (ovr ? cw_mask(reg_a) : NO_BITS);
   assign rd_word = IMPL[reg_a] ? r.regs[reg_a] : ALL_ONES;

   // frame decoder; nothing here looks at the data-path mode
   always_comb begin
      next_r = r;
      // strap synchroniser; the phy address field follows a settled strap
      next_r.a1 = phyad_strap;
      next_r.a2 = r.a1;
      next_r.a3 = r.a2;
      if (r.a2 == r.a3) begin
         next_r.regs[REG_EXT][PHYAD_MSB:PHYAD_LSB] = r.a3;
      end
      // run of ones, saturating so a long preamble stays valid
      if (bit_in) begin
         next_r.ones = (r.ones == PRE_LEN) ? r.ones : r.ones + 6'h01;
      end else begin
         next_r.ones = 6'h00;
      end
      case (r.st)
         ST_HUNT: begin
            // the zero of the delimiter ends the preamble
            if (!bit_in && (r.ones == PRE_LEN || pre_sup)) begin
               next_r.st = ST_SFD;
            end
         end
         ST_SFD: begin
            next_r.cnt = 4'h0;
            next_r.st = bit_in ? ST_HDR : ST_HUNT;
         end
         ST_HDR: begin
            next_r.hdr = hdr_new;
            next_r.cnt = r.cnt + 4'h1;
            if (r.cnt == HDR_LAST) begin
               next_r.st = ST_TA1;
               next_r.rd = (hdr_new[11:10] == OP_RD);
               // only a valid op at our address makes us act
               next_r.act = (hdr_new[11:10] == OP_RD || hdr_new[11:10] == OP_WR)
                  && hdr_new[9:5] == r.regs[REG_EXT][PHYAD_MSB:PHYAD_LSB];
            end
         end
         ST_TA1: begin
            // first turnaround bit stays released, then drive zero
            next_r.st = ST_TA2;
            next_r.sh = rd_word;
            if (r.act && r.rd) begin
               next_r.oe = 1'b1;
               next_r.out = 1'b0;
            end
         end
         ST_TA2: begin
            // a write turnaround is the controller's to drive
            next_r.st = ST_DATA;
            next_r.cnt = 4'h0;
            if (r.act && r.rd) begin
               next_r.out = r.sh[15];
               next_r.sh = {r.sh[14:0], 1'b0};
            end
         end
         ST_DATA: begin
            next_r.cnt = r.cnt + 4'h1;
            if (r.act && r.rd) begin
               next_r.out = r.sh[15];
               next_r.sh = {r.sh[14:0], 1'b0};
            end else begin
               next_r.sh = wr_word;
            end
            if (r.cnt == DATA_LAST) begin
               // back to hunting at once, so a frame may follow directly
               next_r.st = ST_HUNT;
               next_r.ones = 6'h00;
               next_r.oe = 1'b0;
               next_r.out = 1'b0;
               if (r.act && !r.rd) begin
                  if (IMPL[reg_a]) begin
                     next_r.regs[reg_a] = (r.regs[reg_a] & ~wr_mask)
                        | (wr_word & wr_mask);
                     next_r.wtog = !r.wtog;
                     next_r.waddr = reg_a;
                     next_r.wdata = next_r.regs[reg_a];
                  end
                  // override lasts for exactly one write, unless it rearms itself
                  if (reg_a != REG_EXT || !IMPL[reg_a]) begin
                     next_r.regs[REG_EXT][BIT_OVR] = 1'b0;
                  end
               end
            end
         end
         default: begin
            next_r.st = ST_HUNT;
            next_r.oe = 1'b0;
         end
      endcase
   end

   // defaults restored on every reset; override and suppression come up zero
   always_ff @(posedge link.mdc or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
         r.regs[REG_STATUS] <= STATUS_INIT & ~STATUS_CW_MASK;
         r.regs[REG_ID_HI] <= ID_HI_INIT;
         r.regs[REG_ID_LO] <= ID_LO_INIT;
      end else begin
         r <= next_r;
      end
   end

   // line is only ever driven for a matching read
   assign link.mdio_dev_oe = r.oe;
   assign link.mdio_dev_o = r.out;

   // write report crossing: toggle through three flops, counted once the
   // last two agree; address and data stand still for a whole frame after
   always_comb begin
      next_q = q;
      next_q.t1 = r.wtog;
      next_q.t2 = q.t1;
      next_q.t3 = q.t2;
      next_q.pulse = 1'b0;
      if (q.t2 == q.t3 && q.t3 != q.seen) begin
         next_q.seen = q.t3;
         next_q.pulse = 1'b1;
         next_q.addr = r.waddr;
         next_q.data = r.wdata;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign reg_wr_pulse = q.pulse;
   assign reg_wr_addr = q.addr;
   assign reg_wr_data = q.data;
endmodule // mms_dev

// ===== testbench/mms_sva.sv
// checker for the management link wire and the divided link clock.
// assumes the bench instantiates it beside the link interface.
`timescale 1ns/100ps
module mms_sva (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic mdc,
   input wire logic mdio_sta_o,
   input wire logic mdio_sta_oe,
   input wire logic mdio_dev_o,
   input wire logic mdio_dev_oe,
   input wire logic mdio
);
   logic [4:0] drive_len;
   // link edges the device has driven in a row; a counter, as 17 is too long to unroll
   always_ff @(posedge mdc or negedge arst_n) begin
      if (!arst_n) begin
         drive_len <= 5'h00;
      end else begin
         drive_len <= mdio_dev_oe ? drive_len + 5'h01 : 5'h00;
      end
   end
   no_contention_a: assert property (@(posedge mdc) disable iff (!arst_n)
      mdio_dev_oe |-> !mdio_sta_oe && mdio == mdio_dev_o) else $error("both ends drive");
   ta_release_a: assert property (@(posedge mdc) disable iff (!arst_n)
      $rose(mdio_dev_oe) |-> !$past(mdio_sta_oe) && $past(mdio_sta_oe, 2))
      else $error("device drive not one bit after release");
   ta_low_a: assert property (@(posedge mdc) disable iff (!arst_n)
      $rose(mdio_dev_oe) |-> !mdio_dev_o) else $error("turnaround not low");
   drive_len_a: assert property (@(posedge mdc) disable iff (!arst_n)
      $fell(mdio_dev_oe) |-> drive_len == 5'h11) else $error("read drive length wrong");
   sta_hold_a: assert property (@(posedge mdc) disable iff (!arst_n)
      $fell(mdio_sta_oe) |-> !mdio_sta_oe [*8]) else $error("controller took line back");
   mdc_high_a: assert property (@(posedge clock) disable iff (!arst_n)
      $rose(mdc) |-> ##9 mdc ##1 !mdc) else $error("link clock high time wrong");
   sta_stable_a: assert property (@(posedge clock) disable iff (!arst_n)
      mdc && $past(mdc) |-> $stable(mdio_sta_o) && $stable(mdio_sta_oe))
      else $error("controller data moved while clock high");
   dev_edge_a: assert property (@(posedge clock) disable iff (!arst_n)
      ($changed(mdio_dev_oe) || $changed(mdio_dev_o)) |-> $rose(mdc))
      else $error("device output moved off the rising edge");
endmodule // mms_sva

// ===== testbench/mms_test.sv
// self-checking bench: controller and device joined over the link.
// assumes the controller's default divider, so the link clock is 80 ns.
`timescale 1ns/100ps
module mms_test;
   import mms_pkg::*;
   logic clock = 1'b0;
   logic arst_n;
   logic cmd_valid = 1'b0;
   logic cmd_ready;
   logic cmd_write = 1'b0;
   logic cmd_preamble = 1'b1;
   logic [4:0] cmd_phyad = 5'h00;
   logic [4:0] cmd_regad = 5'h00;
   logic [15:0] cmd_wdata = 16'h0000;
   logic resp_valid;
   logic [15:0] resp_rdata;
   logic [4:0] phyad_strap = 5'h00;
   logic reg_wr_pulse;
   logic [4:0] reg_wr_addr;
   logic [15:0] reg_wr_data;
   logic [15:0] rnd = 16'h001E;
   logic [15:0] shadow [32];
   logic ovr = 1'b0;
   logic [15:0] rq [$];
   logic [20:0] wq [$];
   int n_fail = 0;
   int n_tests = 0;
   mms_if link ();
   mms_sta u_mms_sta (.clock(clock), .arst_n(arst_n), .link(link), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_preamble(cmd_preamble),
      .cmd_phyad(cmd_phyad), .cmd_regad(cmd_regad), .cmd_wdata(cmd_wdata),
      .resp_valid(resp_valid), .resp_rdata(resp_rdata));
   mms_dev u_mms_dev (.clock(clock), .arst_n(arst_n), .link(link), .phyad_strap(phyad_strap),
      .reg_wr_pulse(reg_wr_pulse), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));
   mms_sva u_mms_sva (.clock(clock), .arst_n(arst_n), .mdc(link.mdc),
      .mdio_sta_o(link.mdio_sta_o), .mdio_sta_oe(link.mdio_sta_oe),
      .mdio_dev_o(link.mdio_dev_o), .mdio_dev_oe(link.mdio_dev_oe), .mdio(link.mdio));
   // 4 ns system clock
   always #2 clock = ~clock;
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic fail(input string msg);
      n_fail++;
      $display("FAIL %0t %s", $time, msg);
   endtask
   task automatic chk_rd(input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
   endtask
   task automatic chk_wr(input logic [20:0] exp, input logic [20:0] got);
      n_tests++;
      if (got !== exp) fail($sformatf("write report %h expected %h", got, exp));
   endtask
   task automatic results();
      $display("checks %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic done(input string name);
      $display("test %s done", name);
   endtask
   // hand one command over, then wait until the controller is free again
   task automatic xfer(input logic wr, input logic pre, input logic [4:0] phy,
         input logic [4:0] ra, input logic [15:0] d);
      int i;
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_write <= wr;
      cmd_preamble <= pre;
      cmd_phyad <= phy;
      cmd_regad <= ra;
      cmd_wdata <= d;
      @(posedge clock);
      cmd_valid <= 1'b0;
      for (i = 0; i < 3000; i++) begin
         @(negedge clock);
         if (cmd_ready === 1'b1) break;
      end
      if (i == 3000) begin
         fail("controller hung");
         results();
      end
   endtask
   // an ignored or unanswered read sees the pull-up, so all ones
   task automatic rd(input logic pre, input logic [4:0] phy, input logic [4:0] ra);
      rq.push_back((phy == phyad_strap && (pre || shadow[1][BIT_PRE_SUP])
         && IMPL_DEFAULT[ra]) ? shadow[ra] : ALL_ONES);
      xfer(1'b0, pre, phy, ra, 16'h0000);
   endtask
   // expected register effect of a write, worked out from the access types
   task automatic wr(input logic pre, input logic [4:0] phy, input logic [4:0] ra,
         input logic [15:0] d);
      logic [15:0] v;
      v = d;
      if (phy == phyad_strap && (pre || shadow[1][BIT_PRE_SUP])) begin
         if (ra == REG_STATUS) begin
            v = (shadow[REG_STATUS] & ~STATUS_CW_MASK) | (d & STATUS_CW_MASK);
            if (!ovr) v = shadow[REG_STATUS];
         end
         if (ra == REG_ID_HI || ra == REG_ID_LO) v = shadow[ra];
         if (ra == REG_EXT) v = (shadow[16] & ~EXT_RW_MASK) | (d & EXT_RW_MASK);
         ovr = (ra == REG_EXT) && d[BIT_OVR];
         if (IMPL_DEFAULT[ra]) begin
            shadow[ra] = v;
            wq.push_back({ra, v});
         end
         shadow[16][BIT_OVR] = ovr;
      end
      xfer(1'b1, pre, phy, ra, d);
   endtask
   // compare each answer with the oldest note
   always @(posedge clock) begin
      if (resp_valid === 1'b1) begin
         if (rq.size() == 0) fail("unexpected read answer");
         else chk_rd(rq.pop_front(), resp_rdata);
      end
      if (reg_wr_pulse === 1'b1) begin
         if (wq.size() == 0) fail("unexpected write report");
         else chk_wr(wq.pop_front(), {reg_wr_addr, reg_wr_data});
      end
   end
   initial begin
      int k;
      // x to 0 is a falling edge: the mdc-side flops see no clock in reset
      arst_n <= 1'b0;
      rnd = lfsr(rnd);
      phyad_strap = rnd[4:0];
      for (k = 0; k < 32; k++) shadow[k] = 16'h0000;
      shadow[16][PHYAD_MSB:PHYAD_LSB] = phyad_strap;
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      rd(1'b1, phyad_strap, REG_EXT);
      rd(1'b1, phyad_strap, REG_STATUS);
      rd(1'b1, phyad_strap, 5'h1F);
      done("reset values");
      // spread of registers, holes and read-only ones included
      for (k = 0; k < 32; k += 3) begin
         rnd = lfsr(rnd);
         wr(1'b1, phyad_strap, k[4:0], rnd & 16'h7FFF);
         rd(1'b1, phyad_strap, k[4:0]);
      end
      done("write and read back");
      wr(1'b1, phyad_strap, REG_STATUS, 16'hFFFF);
      wr(1'b1, phyad_strap, REG_EXT, 16'hFFFF);
      wr(1'b1, phyad_strap, REG_STATUS, 16'h0040);
      rd(1'b1, phyad_strap, REG_EXT);
      done("override gating");
      for (k = 0; k < 3; k++) begin
         rnd = lfsr(rnd);
         wr(1'b0, phyad_strap, 5'h04, rnd);
         rd(1'b0, phyad_strap, 5'h04);
      end
      done("suppressed preamble");
      wr(1'b0, phyad_strap ^ 5'h01, 5'h04, 16'h1234);
      rd(1'b0, phyad_strap ^ 5'h01, 5'h04);
      rd(1'b0, phyad_strap, 5'h04);
      done("foreign address");
      wr(1'b0, phyad_strap, REG_EXT, 16'h8000);
      wr(1'b0, phyad_strap, REG_STATUS, 16'h0000);
      wr(1'b0, phyad_strap, 5'h04, 16'h5A5A);
      rd(1'b0, phyad_strap, 5'h04);
      rd(1'b1, phyad_strap, 5'h04);
      done("preamble required");
      repeat (20) @(posedge clock);
      n_tests++;
      if (rq.size() + wq.size() != 0) fail("answers missing");
      results();
   end
endmodule // mms_test
